/* File: hdl/tfh_fifo.sv */
`timescale 1ns/100ps
module tfh_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign out_valid = (wptr_r != rptr_r);
  assign in_ready  = (wptr_r != {~rptr_r[AW], rptr_r[AW-1:0]});
  assign out_data  = mem[rptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ****************************************************************
  // Pointers; clear wins so a new packet starts at byte zero
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else if (clear) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  // Storage has no reset; only pointers define content
  always_ff @(posedge clk) begin
    if (push && !clear) begin
      mem[wptr_r[AW-1:0]] <= in_data;
    end
  end

endmodule // tfh_fifo

/* File: hdl/tfh_sync.sv */
`timescale 1ns/100ps
module tfh_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [W-1:0]   d,
  output      logic [W-1:0]   q
);

  logic [W-1:0] meta_r;

  // ****************************************************************
  // Two-flop synchroniser; meta_r feeds only the second stage
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // tfh_sync

/* File: hdl/tfh_task_file.sv */
// Summary of operation
// R1 - Packet opcode arms reception of twelve bytes
// R2 - Firmware reads queue twelve times in order
// R3 - Overlap bit lets device release bus early
// R4 - Release bit reports early bus release
// R5 - Features bit 0 selects DMA or PIO
// R6 - Firmware picks exact host transfer mode
// R7 - Firmware loads error flags and sense key
// R8 - Error register: sense key, four flags
// R9 - Sector count reserved in ATAPI mode
// R10 - Direction, request, command bit encode phase
// R11 - Direction bit one means device to host
// R12 - Command bit set in command, status phases
// R13 - Tag register reserved in ATAPI mode
// R14 - Byte count pair gives per-request limit
// R15 - Host writes other than data ignored while busy or requesting
// R16 - Busy makes every address read status
// R17 - New packet clears queue pointers
`timescale 1ns/100ps
`include "tfh_map.svh"
module tfh_task_file #(
  parameter int unsigned FIFO_DEPTH = `TFH_FIFO_DEPTH
) (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire tfh_pkg::tfh_host_pins_s host_pins,
  output      logic [15:0]             dd_out,
  output      logic                    dd_oe,
  input  wire tfh_pkg::tfh_fw_req_s    fw_req,
  output      logic [7:0]              fw_rdata,
  output      logic                    fw_rvalid,
  input  wire logic [7:0]              status_img,
  input  wire logic                    atapi_mode,
  output      logic                    dma_select,
  output      logic                    overlap_ok,
  output      logic                    release_flag,
  output      tfh_pkg::tfh_phase_e     phase,
  output      logic [15:0]             byte_limit,
  output      logic                    packet_ready,
  output      logic                    cmd_request,
  output      logic                    new_cmd,
  output      logic [7:0]              host_cmd
);
  import tfh_pkg::*;

  // ****************************************************************
  // Reset release and host pin synchronisation
  // ****************************************************************
  logic [1:0]     rst_pipe_r;
  logic           rst_n;
  tfh_host_pins_s hp;
  tfh_state_s     st_r;
  tfh_state_s     st_nxt;
  logic           fifo_push;
  logic           fifo_pop;
  logic           fifo_clear;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic [15:0]    fifo_out_data;

  // Reset asserts at once, releases two clocks later
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // Strobes idle high, so reset them high to avoid a false edge
  tfh_sync #(
    .W       ($bits(tfh_host_pins_s)),
    .RST_VAL ({$bits(tfh_host_pins_s){1'b1}})
  ) u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (host_pins),
    .q     (hp)
  );

  // ****************************************************************
  // Packet queue, one host word per entry
  // ****************************************************************
  tfh_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .clear     (fifo_clear),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (st_r.dd_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Phase from direction, data request and command bit
  function automatic tfh_phase_e phase_of(input logic io, input logic drq, input logic command_or_payload);
    unique case ({io, drq, command_or_payload})
      3'b011:  phase_of = TFH_PH_CMD;     // R10
      3'b110:  phase_of = TFH_PH_TOHOST;  // R10
      3'b010:  phase_of = TFH_PH_FRHOST;  // R10
      3'b101:  phase_of = TFH_PH_STATUS;  // R10
      default: phase_of = TFH_PH_NONE;
    endcase
  endfunction

  // ****************************************************************
  // Next-state logic: host pins, firmware port, packet tracking
  // ****************************************************************
  always_comb begin
    logic       sel;
    logic       hwr;
    logic       owned;
    logic       busy;
    logic [7:0] hval;
    sel        = !hp.cs0_n && hp.cs1_n;
    hwr        = sel && !st_r.diow_q && hp.diow_n;
    busy       = status_img[`TFH_ST_BSY];
    owned      = busy || status_img[`TFH_ST_DRQ] || st_r.cmd_drq;
    hval       = st_r.dd_q[7:0];
    st_nxt     = st_r;
    fifo_push  = 1'b0;
    fifo_pop   = 1'b0;
    fifo_clear = 1'b0;
    st_nxt.new_cmd   = 1'b0;
    st_nxt.fw_rvalid = fw_req.rd;
    st_nxt.diow_q    = hp.diow_n;
    // Data is taken from the sample before the strobe's rising edge
    if (!hp.diow_n) begin
      st_nxt.dd_q = hp.dd_in;
    end

    // Host write, decoded at the end of the write strobe
    if (hwr) begin
      if (hp.da == `TFH_HA_DATA) begin
        // Full queue refuses the word; ready stalls the count too
        if (st_r.pk == TFH_PK_RECV && fifo_in_ready) begin
          fifo_push    = 1'b1;                                     // R1
          st_nxt.words = st_r.words + 3'h1;
          if (st_r.words == `TFH_PKT_WORDS - 3'h1) begin
            st_nxt.pk      = TFH_PK_HELD;                          // R1
            st_nxt.cmd_drq = 1'b0;
          end
        end
      end else if (!owned) begin                                   // R15
        unique case (hp.da)
          `TFH_HA_ERR_FEAT: st_nxt.feat = hval;                    // R5
          `TFH_HA_CAUSE:    if (!atapi_mode) st_nxt.sect = hval;   // R9
          `TFH_HA_TAG:      if (!atapi_mode) st_nxt.tag = hval;    // R13
          `TFH_HA_BCL:      st_nxt.bcl = hval;                     // R14
          `TFH_HA_BCH:      st_nxt.bch = hval;                     // R14
          `TFH_HA_STAT_CMD: begin
            st_nxt.cmd     = hval;
            st_nxt.new_cmd = 1'b1;
            if (hval == `TFH_PKT_OPCODE) begin
              fifo_clear        = 1'b1;                            // R17
              st_nxt.pk         = TFH_PK_RECV;                     // R1
              st_nxt.cmd_drq    = 1'b1;
              st_nxt.words      = 3'h0;
              st_nxt.rbytes     = 4'h0;
              st_nxt.q_hi       = 1'b0;
              st_nxt.overlap_ok = st_r.feat[`TFH_FEAT_OVL];        // R3
              st_nxt.cause      = 8'h00;
              st_nxt.cause[`TFH_CAUSE_COD] = 1'b1;                 // R12
              st_nxt.cause[`TFH_CAUSE_IO]  = 1'b0;                 // R11
            end
          end
          default: ;
        endcase
      end
    end

    // Firmware writes land after host writes, so firmware wins a tie
    if (fw_req.wr) begin
      unique case (fw_req.addr)
        `TFH_FW_FEAT_ERR:  st_nxt.err = fw_req.wdata;                    // R8
        `TFH_FW_SECT_CAUS: st_nxt.cause = fw_req.wdata & `TFH_CAUSE_MASK; // R4
        `TFH_FW_TAG:       st_nxt.tag = fw_req.wdata;
        `TFH_FW_BCL:       st_nxt.bcl = fw_req.wdata;
        `TFH_FW_BCH:       st_nxt.bch = fw_req.wdata;
        default: ;
      endcase
    end

    // Firmware reads; queue gives low byte then high byte of each word
    st_nxt.fw_rdata = 8'h00;
    if (fw_req.rd) begin
      unique case (fw_req.addr)
        `TFH_FW_QUEUE: begin
          if (fifo_out_valid) begin
            st_nxt.fw_rdata = st_r.q_hi ? fifo_out_data[15:8] : fifo_out_data[7:0];
            st_nxt.q_hi     = !st_r.q_hi;
            fifo_pop        = st_r.q_hi;
            st_nxt.rbytes   = st_r.rbytes + 4'h1;
            if (st_r.pk == TFH_PK_HELD && st_r.rbytes == `TFH_PKT_BYTES - 4'h1) begin
              st_nxt.pk = TFH_PK_IDLE;
            end
          end
        end
        `TFH_FW_FEAT_ERR:  st_nxt.fw_rdata = st_r.feat;
        `TFH_FW_SECT_CAUS: st_nxt.fw_rdata = st_r.sect;
        `TFH_FW_TAG:       st_nxt.fw_rdata = st_r.tag;
        `TFH_FW_BCL:       st_nxt.fw_rdata = st_r.bcl;
        `TFH_FW_BCH:       st_nxt.fw_rdata = st_r.bch;
        default:           st_nxt.fw_rdata = 8'h00;
      endcase
    end

    // Host read data; busy hides the whole file behind status
    st_nxt.dd_oe  = sel && !hp.dior_n;
    st_nxt.dd_out = 16'h0000;
    if (busy) begin
      st_nxt.dd_out[7:0] = status_img;                             // R16
    end else begin
      unique case (hp.da)
        `TFH_HA_ERR_FEAT: st_nxt.dd_out[7:0] = st_r.err;
        `TFH_HA_CAUSE:    st_nxt.dd_out[7:0] = atapi_mode ? st_r.cause : st_r.sect;
        `TFH_HA_TAG:      st_nxt.dd_out[7:0] = atapi_mode ? 8'h00 : st_r.tag;
        `TFH_HA_BCL:      st_nxt.dd_out[7:0] = st_r.bcl;
        `TFH_HA_BCH:      st_nxt.dd_out[7:0] = st_r.bch;
        `TFH_HA_STAT_CMD: st_nxt.dd_out[7:0] = status_img;
        default:          st_nxt.dd_out = 16'h0000;
      endcase
    end

    st_nxt.phase = phase_of(st_r.cause[`TFH_CAUSE_IO],
                            status_img[`TFH_ST_DRQ] || st_r.cmd_drq,
                            st_r.cause[`TFH_CAUSE_COD]);           // R10
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r            <= '0;
      st_r.pk         <= TFH_PK_IDLE;
      st_r.phase      <= TFH_PH_NONE;
      st_r.diow_q     <= 1'b1;
      st_r.dd_q       <= 16'h0000;
      st_r.feat       <= `TFH_RST_BYTE;
      st_r.err        <= `TFH_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign dd_out       = st_r.dd_out;
  assign dd_oe        = st_r.dd_oe;
  assign fw_rdata     = st_r.fw_rdata;
  assign fw_rvalid    = st_r.fw_rvalid;
  assign dma_select   = st_r.feat[`TFH_FEAT_DMA];     // R5
  assign overlap_ok   = st_r.overlap_ok;
  assign release_flag = st_r.cause[`TFH_CAUSE_REL];   // R4
  assign phase        = st_r.phase;
  assign byte_limit   = {st_r.bch, st_r.bcl};         // R14
  assign packet_ready = st_r.pk[2];                   // R2 One-hot bit of the held state, no gate
  assign cmd_request  = st_r.cmd_drq;
  assign new_cmd      = st_r.new_cmd;
  assign host_cmd     = st_r.cmd;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic hwr_a;
  logic owned_a;
  assign hwr_a   = !hp.cs0_n && hp.cs1_n && !st_r.diow_q && hp.diow_n;
  assign owned_a = status_img[`TFH_ST_BSY] || status_img[`TFH_ST_DRQ] || st_r.cmd_drq;

  sequence pkt_cmd_s;
    hwr_a && !owned_a && hp.da == `TFH_HA_STAT_CMD && st_r.dd_q[7:0] == `TFH_PKT_OPCODE;
  endsequence

  sequence pkt_armed_s;
    st_r.pk == TFH_PK_RECV && st_r.cmd_drq && st_r.words == 3'h0;
  endsequence

  pkt_start_a: assert property (pkt_cmd_s |=> pkt_armed_s) // R1
    else $error("packet opcode did not arm reception");

  pkt_words_a: assert property (st_r.words <= `TFH_PKT_WORDS) // R1
    else $error("more than six packet words accepted");

  pkt_flush_a: assert property (pkt_cmd_s |=> !fifo_out_valid) // R17
    else $error("queue not empty after new packet");

  // Firmware may overwrite the cause in the opcode cycle; it wins that tie
  cause_init_a: assert property (pkt_cmd_s ##0 !fw_req.wr ##1 (!fw_req.wr) [*2] |->
                                 phase == TFH_PH_CMD) // R12
    else $error("command phase not shown after packet opcode");

  io_dir_a: assert property (pkt_cmd_s ##0 !fw_req.wr |=>
                             !st_r.cause[`TFH_CAUSE_IO] && st_r.cause[`TFH_CAUSE_COD]) // R11
    else $error("direction bit wrong for command receive");

  busy_read_a: assert property (status_img[`TFH_ST_BSY] |=> dd_out[7:0] == $past(status_img)) // R16
    else $error("busy read did not return status");

  busy_write_a: assert property (hwr_a && owned_a && hp.da == `TFH_HA_BCL && !fw_req.wr |=>
                                 $stable(st_r.bcl)) // R15
    else $error("task-file write taken while owned");

  dma_sel_a: assert property (hwr_a && !owned_a && hp.da == `TFH_HA_ERR_FEAT |=>
                              dma_select == $past(st_r.dd_q[`TFH_FEAT_DMA])) // R5
    else $error("DMA select does not follow feature bit");

  err_layout_a: assert property (fw_req.wr && fw_req.addr == `TFH_FW_FEAT_ERR |=>
                                 st_r.err == $past(fw_req.wdata)) // R8
    else $error("error register not loaded as written");

  tag_resv_a: assert property (atapi_mode && hwr_a && hp.da == `TFH_HA_TAG && !fw_req.wr |=>
                               $stable(st_r.tag)) // R13
    else $error("tag written by host in ATAPI mode");

endmodule // tfh_task_file

/* File: include/tfh_map.svh */
`ifndef TFH_MAP_SVH
`define TFH_MAP_SVH

// ****************************************************************
// Host task-file addresses (device address lines)
// ****************************************************************
`define TFH_HA_DATA      3'h0
`define TFH_HA_ERR_FEAT  3'h1
`define TFH_HA_CAUSE     3'h2
`define TFH_HA_TAG       3'h3
`define TFH_HA_BCL       3'h4
`define TFH_HA_BCH       3'h5
`define TFH_HA_STAT_CMD  3'h7

// ****************************************************************
// Firmware register offsets
// ****************************************************************
`define TFH_FW_QUEUE     8'h00
`define TFH_FW_FEAT_ERR  8'h01
`define TFH_FW_SECT_CAUS 8'h02
`define TFH_FW_TAG       8'h03
`define TFH_FW_BCL       8'h04
`define TFH_FW_BCH       8'h05

// ****************************************************************
// Field positions and constants
// ****************************************************************
`define TFH_FEAT_DMA     0
`define TFH_FEAT_OVL     1
`define TFH_CAUSE_COD    0
`define TFH_CAUSE_IO     1
`define TFH_CAUSE_REL    2
`define TFH_CAUSE_MASK   8'h07
`define TFH_ST_BSY       7
`define TFH_ST_DRQ       3
`define TFH_PKT_OPCODE   8'hA0
`define TFH_PKT_WORDS    3'h6
`define TFH_PKT_BYTES    4'hC
`define TFH_FIFO_DEPTH   16
`define TFH_RST_BYTE     8'h00

`endif

/* File: include/tfh_pkg.sv */
package tfh_pkg;

  // Packet reception progress, one-hot
  typedef enum logic [2:0] {
    TFH_PK_IDLE = 3'b001,
    TFH_PK_RECV = 3'b010,
    TFH_PK_HELD = 3'b100
  } tfh_pk_e;

  // Command phase as seen by the host, one-hot
  typedef enum logic [4:0] {
    TFH_PH_NONE   = 5'b00001,
    TFH_PH_CMD    = 5'b00010,
    TFH_PH_TOHOST = 5'b00100,
    TFH_PH_FRHOST = 5'b01000,
    TFH_PH_STATUS = 5'b10000
  } tfh_phase_e;

  // Host-side pins as they arrive, all asynchronous to core_clk
  typedef struct packed {
    logic        cs0_n;
    logic        cs1_n;
    logic [2:0]  da;
    logic        dior_n;
    logic        diow_n;
    logic [15:0] dd_in;
  } tfh_host_pins_s;

  // Firmware register request, same clock as the block
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tfh_fw_req_s;

  // Registered state of the task-file block, apart from the queue, pin synchroniser and reset pipe
  typedef struct packed {
    tfh_pk_e     pk;
    tfh_phase_e  phase;
    logic        diow_q;
    logic [15:0] dd_q;
    logic [7:0]  feat;
    logic [7:0]  err;
    logic [7:0]  sect;
    logic [7:0]  cause;
    logic [7:0]  tag;
    logic [7:0]  bcl;
    logic [7:0]  bch;
    logic [7:0]  cmd;
    logic        new_cmd;
    logic        cmd_drq;
    logic [2:0]  words;
    logic [3:0]  rbytes;
    logic        q_hi;
    logic        overlap_ok;
    logic [15:0] dd_out;
    logic        dd_oe;
    logic [7:0]  fw_rdata;
    logic        fw_rvalid;
  } tfh_state_s;

endpackage

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import tfh_pkg::*;
  logic           core_clk;
  logic           arst_n;
  tfh_host_pins_s host_pins;
  tfh_fw_req_s    fw_req;
  logic [15:0]    dd_out;
  logic [15:0]    byte_limit;
  logic           dd_oe;
  logic           fw_rvalid;
  logic           atapi_mode;
  logic           dma_select;
  logic           overlap_ok;
  logic           release_flag;
  logic           packet_ready;
  logic           cmd_request;
  logic           new_cmd;
  logic [7:0]     fw_rdata;
  logic [7:0]     status_img;
  logic [7:0]     host_cmd;
  tfh_phase_e     phase;
  int             error_cnt;
  int             tests_run;
  int             cmd_cnt;

  tfh_task_file #(.FIFO_DEPTH(16)) u_tfh_task_file (
    .core_clk(core_clk), .arst_n(arst_n), .host_pins(host_pins), .dd_out(dd_out), .dd_oe(dd_oe),
    .fw_req(fw_req), .fw_rdata(fw_rdata), .fw_rvalid(fw_rvalid), .status_img(status_img),
    .atapi_mode(atapi_mode), .dma_select(dma_select), .overlap_ok(overlap_ok),
    .release_flag(release_flag), .phase(phase), .byte_limit(byte_limit),
    .packet_ready(packet_ready), .cmd_request(cmd_request), .new_cmd(new_cmd), .host_cmd(host_cmd));

  tfh_host_model u_tfh_host_model (.clk(core_clk), .pins(host_pins), .dd_out(dd_out), .dd_oe(dd_oe));

  // ****
  // Clock, pulse counter and shared tasks
  // ****
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Count command pulses on the edge where they stand
  always @(posedge core_clk) begin
    if (new_cmd === 1'b1) cmd_cnt++;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic fw_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    fw_req.wr = 1'b1;
    fw_req.addr = a;
    fw_req.wdata = d;
    @(negedge core_clk);
    fw_req.wr = 1'b0;
  endtask

  // Firmware read; answer waited for a bounded number of cycles
  task automatic fw_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    int n;
    @(negedge core_clk);
    fw_req.rd = 1'b1;
    fw_req.addr = a;
    @(negedge core_clk);
    fw_req.rd = 1'b0;
    n = 0;
    while (fw_rvalid !== 1'b1 && n < 3) begin
      @(negedge core_clk);
      n++;
    end
    chk({name, " valid"}, 16'h0001, {15'h0000, fw_rvalid});
    if (fw_rvalid !== 1'b1) wrap_up(); // Limit ran out; the mismatch is counted above
    chk(name, {8'h00, exp}, {8'h00, fw_rdata});
  endtask

  task automatic host_rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    logic [15:0] d;
    logic        oe;
    u_tfh_host_model.rd(a, d, oe);
    chk({name, " oe"}, 16'h0001, {15'h0000, oe});
    chk(name, {8'h00, exp}, {8'h00, d[7:0]});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk("phase", {11'h000, TFH_PH_NONE}, {11'h000, phase});
    fw_rd(8'h01, 8'h00, "features");
    fw_rd(8'h20, 8'h00, "unmapped");
  endtask

  task automatic t_limit();
    u_tfh_host_model.wr(3'h4, 16'h0034);
    u_tfh_host_model.wr(3'h5, 16'h0012);
    chk("byte_limit", 16'h1234, byte_limit);
    fw_wr(8'h04, 8'hAB);
    fw_wr(8'h20, 8'h5A);
    fw_rd(8'h04, 8'hAB, "limit low");
    fw_rd(8'h20, 8'h00, "unmapped");
    chk("byte_limit", 16'h12AB, byte_limit);
  endtask

  // Error flags and sense key, each flag set once and clear once
  task automatic t_err();
    logic [7:0] v[2] = '{8'hA5, 8'h5A};
    foreach (v[i]) begin
      fw_wr(8'h01, v[i]);
      host_rd(3'h1, v[i], "error");
    end
  endtask

  task automatic t_packet(input logic [7:0] base, input logic ovl);
    u_tfh_host_model.wr(3'h1, {14'h0000, ovl, 1'b1});
    chk("dma_select", 16'h0001, {15'h0000, dma_select});
    fw_rd(8'h01, {6'h00, ovl, 1'b1}, "features");
    u_tfh_host_model.wr(3'h7, 16'h00A0);
    chk("host_cmd", 16'h00A0, {8'h00, host_cmd});
    chk("cmd_request", 16'h0001, {15'h0000, cmd_request});
    chk("overlap_ok", {15'h0000, ovl}, {15'h0000, overlap_ok});
    chk("phase", {11'h000, TFH_PH_CMD}, {11'h000, phase});
    u_tfh_host_model.wr(3'h4, 16'h0099);
    chk("byte_limit", 16'h12AB, byte_limit);
    for (int k = 0; k < 6; k++) begin
      u_tfh_host_model.wr(3'h0, {base + 8'(2 * k + 1), base + 8'(2 * k)});
    end
    chk("cmd_request", 16'h0000, {15'h0000, cmd_request});
    chk("packet_ready", 16'h0001, {15'h0000, packet_ready});
    for (int i = 0; i < 12; i++) begin
      fw_rd(8'h00, base + 8'(i), "queue byte");
    end
    fw_rd(8'h00, 8'h00, "empty queue");
    chk("packet_ready", 16'h0000, {15'h0000, packet_ready});
    u_tfh_host_model.wr(3'h1, 16'h0000);
    chk("dma_select", 16'h0000, {15'h0000, dma_select});
  endtask

  // Phase table walked row by row, plus the release bit
  task automatic t_phase();
    logic [2:0]  c[5] = '{3'b001, 3'b010, 3'b000, 3'b011, 3'b111};
    logic        q[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    tfh_phase_e  p[5] = '{TFH_PH_CMD, TFH_PH_TOHOST, TFH_PH_FRHOST, TFH_PH_STATUS, TFH_PH_STATUS};
    foreach (c[i]) begin
      status_img = {4'h0, q[i], 3'h0};
      fw_wr(8'h02, {5'h00, c[i]});
      repeat (3) @(negedge core_clk);
      chk("phase", {11'h000, p[i]}, {11'h000, phase});
      chk("release_flag", {15'h0000, c[i][2]}, {15'h0000, release_flag});
      host_rd(3'h2, {5'h00, c[i]}, "cause");
    end
    status_img = 8'h00;
  endtask

  task automatic t_busy();
    status_img = 8'hC1;
    host_rd(3'h4, 8'hC1, "busy limit low");
    host_rd(3'h1, 8'hC1, "busy error");
    u_tfh_host_model.wr(3'h4, 16'h0077);
    status_img = 8'h00;
    chk("byte_limit", 16'h12AB, byte_limit);
  endtask

  task automatic t_mode();
    fw_wr(8'h03, 8'h11);
    fw_rd(8'h03, 8'h11, "tag");
    atapi_mode = 1'b1;
    u_tfh_host_model.wr(3'h3, 16'h0042);
    u_tfh_host_model.wr(3'h2, 16'h0017);
    fw_rd(8'h03, 8'h11, "tag reserved");
    fw_rd(8'h02, 8'h00, "sector reserved");
    atapi_mode = 1'b0;
    u_tfh_host_model.wr(3'h3, 16'h0042);
    u_tfh_host_model.wr(3'h2, 16'h0017);
    fw_rd(8'h03, 8'h42, "tag");
    fw_rd(8'h02, 8'h17, "sector");
  endtask

  // A new opcode over an unread packet must drop it; leftovers would show first
  task automatic t_flush();
    for (int j = 0; j < 2; j++) begin
      u_tfh_host_model.wr(3'h7, 16'h00A0);
      for (int k = 0; k < 6; k++) begin
        u_tfh_host_model.wr(3'h0, {8'h41 + 8'(32 * j + 2 * k), 8'h40 + 8'(32 * j + 2 * k)});
      end
    end
    for (int i = 0; i < 12; i++) begin
      fw_rd(8'h00, 8'h60 + 8'(i), "flushed queue byte");
    end
    chk("packet_ready", 16'h0000, {15'h0000, packet_ready});
    chk("new_cmd pulses", 16'h0004, 16'(cmd_cnt));
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    arst_n = 1'b0;
    fw_req = '0;
    status_img = 8'h00;
    atapi_mode = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    cmd_cnt = 0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    t_reset();
    t_limit();
    t_err();
    t_packet(8'h30, 1'b1);
    t_packet(8'h80, 1'b0);
    chk("new_cmd pulses", 16'h0002, 16'(cmd_cnt));
    t_flush();
    t_phase();
    t_busy();
    t_mode();
    wrap_up();
  end
endmodule // testbench

/* File: test/tfh_host_model.sv */
`timescale 1ns/100ps
module tfh_host_model (
  input  wire logic                    clk,
  output      tfh_pkg::tfh_host_pins_s pins,
  input  wire logic [15:0]             dd_out,
  input  wire logic                    dd_oe
);
  import tfh_pkg::*;

  // Idle bus: deselected, both strobes high
  initial begin
    pins = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 16'hFFFF};
  end

  // Four cycles per phase keeps each strobe above the 2-cycle sync minimum
  task automatic hold4();
    repeat (4) @(negedge clk);
  endtask

  // Register write; data stays put until the strobe has risen
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    pins.cs0_n = 1'b0;
    pins.da = a;
    pins.dd_in = d;
    hold4();
    pins.diow_n = 1'b0;
    hold4();
    pins.diow_n = 1'b1;
    hold4();
    pins.cs0_n = 1'b1;
    pins.dd_in = ~d; // Released bus never repeats the last word
    hold4();
  endtask

  // Register read; sampled well after the 3-cycle answer latency
  task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic oe);
    @(negedge clk);
    pins.cs0_n = 1'b0;
    pins.da = a;
    hold4();
    pins.dior_n = 1'b0;
    hold4();
    hold4();
    d = dd_out;
    oe = dd_oe;
    pins.dior_n = 1'b1;
    hold4();
    pins.cs0_n = 1'b1;
    hold4();
  endtask
endmodule // tfh_host_model
